// ---- pkg/ebm_pkg.sv ----
//==========================================
// external bus mode and hold constants
package ebm_pkg;
	// register indices; byte address is four times the index
	localparam logic [31:0] PINSEL_IDX  = 32'h0080_0747;
	localparam logic [31:0] MODE_IDX    = 32'h0080_077f;
	localparam logic [31:0] STAT_IDX    = 32'h0080_0780;
	localparam logic [31:0] PINSEL_ADDR = PINSEL_IDX << 2;
	localparam logic [31:0] MODE_ADDR   = MODE_IDX << 2;
	localparam logic [31:0] STAT_ADDR   = STAT_IDX << 2;
	//==========================================
	// pin select fields, msb first order
	localparam int SEL_CLKWR_BIT = 7;
	localparam int SEL_WAIT_BIT  = 6;
	localparam int SEL_HOLD_REQUEST_N_BIT  = 5;
	localparam int SEL_HOLD_ACKNOWLEDGE_N_BIT  = 4;
	localparam int SEL_DBG_LSB   = 0;
	localparam int MODE_BIT      = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_HOLD_BIT = 1;
	localparam int STAT_MODE_BIT = 2;
	localparam int STAT_BOOT_BIT = 3;
	localparam int STAT_SCHP_BIT = 4;
	localparam logic [7:0] PINSEL_RST = 8'h00;
	localparam logic       MODE_RST   = 1'h0;
	//==========================================
	// timing: bus clock is half the cpu clock
	localparam int BCLK_DIV        = 2;
	localparam int MIN_BUS_PERIODS = 2;
	localparam int MIN_ACC_CLKS    = MIN_BUS_PERIODS * BCLK_DIV;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	//==========================================
	// carriers
	typedef struct packed {
		logic        write;
		logic        area;
		logic [1:0]  be;
		logic [18:0] addr;
		logic [15:0] wdata;
	} ebm_req_t;
	typedef struct packed {
		logic        err;
		logic [15:0] rdata;
	} ebm_rsp_t;
	typedef struct packed {
		logic [18:0] addr;
		logic        addr_oe;
		logic [15:0] dout;
		logic        dout_oe;
		logic [1:0]  area_select_n;
		logic        rd_n;
		logic        high_byte_n;
		logic        low_byte_n;
		logic        strobe_oe;
		logic        clk_wr;
		logic        clk_wr_oe;
	} ebm_pins_t;
endpackage

// ---- design/ebm_bclk_div.sv ----
`timescale 1ns/1ps
//==========================================
// bus clock divider with period enable
module ebm_bclk_div
	import ebm_pkg::*;
#(
	parameter int DIV = BCLK_DIV
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// divided outputs
	output logic      bclk,
	output logic      en
);
	localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          bclk_nxt;
	logic          en_nxt;

	// next count; en marks the end of each bus period
	always_comb begin
		cnt_nxt  = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
		en_nxt   = (cnt_r == LAST);
		bclk_nxt = (cnt_nxt < HALF);
	end

	// register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			bclk  <= 1'h1;
			en    <= 1'h0;
		end else begin
			cnt_r <= cnt_nxt;
			bclk  <= bclk_nxt;
			en    <= en_nxt;
		end
	end
endmodule

// ---- design/ebm_hold_arb.sv ----
`timescale 1ns/1ps
//==========================================
// hold request arbitration
module ebm_hold_arb
	import ebm_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic hold_request_n_sel,
	input  wire logic hold_acknowledge_n_sel,
	input  wire logic hold_request_n,
	input  wire logic bus_idle,
	// results
	output logic      hold_acknowledge_n,
	output logic      hold_acknowledge_n_oe,
	output logic      bus_float,
	output logic      in_hold
);
	typedef enum logic [1:0] {AR_NORM, AR_ENTER, AR_HOLD} ebm_arb_t;
	ebm_arb_t st_r;
	ebm_arb_t st_nxt;
	logic     hold_acknowledge_n_nxt;
	logic     float_nxt;

	// grant only at a cycle boundary, leave when request released
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			AR_NORM: begin
				if (hold_request_n_sel && !hold_request_n && bus_idle) begin
					st_nxt = AR_ENTER;
				end
			end
			AR_ENTER: begin
				st_nxt = AR_HOLD;
			end
			AR_HOLD: begin
				if (hold_request_n || !hold_request_n_sel) begin
					st_nxt = AR_NORM;
				end
			end
		endcase
		hold_acknowledge_n_nxt  = (st_nxt == AR_NORM);
		float_nxt = (st_nxt == AR_HOLD);
	end

	// register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r               <= AR_NORM;
			hold_acknowledge_n <= 1'h1;
			hold_acknowledge_n_oe            <= 1'h0;
			bus_float          <= 1'h0;
		end else begin
			st_r               <= st_nxt;
			hold_acknowledge_n <= hold_acknowledge_n_nxt;
			hold_acknowledge_n_oe            <= hold_acknowledge_n_sel;
			bus_float          <= float_nxt;
		end
	end
	assign in_hold = (st_r != AR_NORM);

	//==========================================
	// checks
	a_hold_grant: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == AR_NORM && hold_request_n_sel && !hold_request_n && bus_idle)
		|=> !hold_acknowledge_n ##1 bus_float)
		else $error("hold not granted");
	a_float_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_float |-> !hold_acknowledge_n)
		else $error("float without acknowledge");
	a_hold_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == AR_HOLD && hold_request_n) |=> hold_acknowledge_n && !bus_float)
		else $error("hold not left");
	c_hold_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
		bus_float ##[1:50] !bus_float);
endmodule

// ---- design/ebm_ext_bus.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//==========================================
// external bus interface with mode and hold logic
// Contract
// - four select bits pick bus pin function
// - bits zero to three pick debug functions
// - mode bit picks strobe or enable mode
// - mode zero: byte writes, read, clock, wait
// - boot mode forces write strobe mode
// - mode one: byte enables, shared write, no clock
// - mode zero read: read low, writes high
// - mode zero write: written lane strobe low
// - wait low keeps inserting wait cycles
// - every access lasts two bus periods minimum
// - mode one read: read and lane enables low
// - mode one write: write and lane enables low
// - low hold request enters hold, acknowledge low
// - hold floats all bus outputs
// - released hold request resumes normal bus
// - no external access in single chip mode
// - high byte is upper data lanes
// - nineteen address lines, all bits driven from the request
// - acknowledge low already while entering hold
module ebm_ext_bus
	import ebm_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// chip modes
	input  wire logic        boot_mode,
	input  wire logic        single_chip,
	// cpu access port
	input  wire logic        req_valid,
	input  wire ebm_req_t    req,
	output logic             req_ready,
	output logic             rsp_valid,
	output ebm_rsp_t         rsp,
	// external pins
	output ebm_pins_t        bus,
	input  wire logic [15:0] data_in,
	input  wire logic        wait_n,
	input  wire logic        hold_request_n,
	output logic             hold_acknowledge_n,
	output logic             hold_ack_oe,
	// port function selects
	output logic [7:0]       shared_pin_sel,
	output logic [3:0]       debug_link_sel
);
	typedef enum logic [1:0] {ST_IDLE, ST_T1, ST_TW} ebm_st_t;
	//==========================================
	// register file state
	logic [7:0]  pinsel_r;
	logic [7:0]  pinsel_nxt;
	logic        mode_r;
	logic        mode_nxt;
	logic        awready_nxt;
	logic        bvalid_nxt;
	logic [1:0]  bresp_nxt;
	logic        arready_nxt;
	logic        rvalid_nxt;
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_nxt;
	// bus engine state
	ebm_st_t     st_r;
	ebm_st_t     st_nxt;
	ebm_req_t    cur_r;
	ebm_req_t    cur_nxt;
	ebm_pins_t   pins_nxt;
	logic        ready_nxt;
	logic        rspv_nxt;
	ebm_rsp_t    rsp_nxt;
	logic [15:0] lane_rd;
	logic        bclk;
	logic        en;
	logic        bus_float;
	logic        in_hold;
	logic        mode_eff;
	logic        wait_hold;
	logic        hold_block;
	logic        go;

	assign mode_eff   = mode_r && !boot_mode;
	assign wait_hold  = pinsel_r[SEL_WAIT_BIT] && !wait_n;
	assign hold_block = in_hold || (pinsel_r[SEL_HOLD_REQUEST_N_BIT] && !hold_request_n);
	assign go         = en && st_r == ST_IDLE && req_valid && !hold_block;
	assign shared_pin_sel = pinsel_r;
	assign debug_link_sel = pinsel_r[SEL_DBG_LSB +: 4];
	assign s_axi_wready   = s_axi_awready;

	//==========================================
	// bus clock divider and hold arbiter
	ebm_bclk_div #(
		.DIV (BCLK_DIV)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.bclk    (bclk),
		.en      (en)
	);
	ebm_hold_arb u_arb (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.hold_request_n_sel           (pinsel_r[SEL_HOLD_REQUEST_N_BIT]),
		.hold_acknowledge_n_sel           (pinsel_r[SEL_HOLD_ACKNOWLEDGE_N_BIT]),
		.hold_request_n     (hold_request_n),
		.bus_idle           (st_r == ST_IDLE),
		.hold_acknowledge_n (hold_acknowledge_n),
		.hold_acknowledge_n_oe            (hold_ack_oe),
		.bus_float          (bus_float),
		.in_hold            (in_hold)
	);

	//==========================================
	// axi4-lite slave: write waits for address and data together
	always_comb begin
		pinsel_nxt  = pinsel_r;
		mode_nxt    = mode_r;
		awready_nxt = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
		bvalid_nxt  = s_axi_bvalid && !s_axi_bready;
		bresp_nxt   = s_axi_bresp;
		if (s_axi_awready) begin
			bvalid_nxt = 1'h1;
			bresp_nxt  = RESP_OKAY;
			if (s_axi_awaddr[31:2] == PINSEL_ADDR[31:2]) begin
				if (s_axi_wstrb[0]) begin
					pinsel_nxt = s_axi_wdata[7:0];
				end
			end else if (s_axi_awaddr[31:2] == MODE_ADDR[31:2]) begin
				if (s_axi_wstrb[0]) begin
					mode_nxt = s_axi_wdata[MODE_BIT];
				end
			end else if (s_axi_awaddr[31:2] != STAT_ADDR[31:2]) begin
				bresp_nxt = RESP_SLVERR;
			end
		end
	end

	// read side; upper bits read as zero
	always_comb begin
		arready_nxt = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		rvalid_nxt  = s_axi_rvalid && !s_axi_rready;
		rdata_nxt   = s_axi_rdata;
		rresp_nxt   = s_axi_rresp;
		if (s_axi_arready) begin
			rvalid_nxt = 1'h1;
			rresp_nxt  = RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			if (s_axi_araddr[31:2] == PINSEL_ADDR[31:2]) begin
				rdata_nxt[7:0] = pinsel_r;
			end else if (s_axi_araddr[31:2] == MODE_ADDR[31:2]) begin
				rdata_nxt[MODE_BIT] = mode_r;
			end else if (s_axi_araddr[31:2] == STAT_ADDR[31:2]) begin
				rdata_nxt[STAT_BUSY_BIT] = (st_r != ST_IDLE);
				rdata_nxt[STAT_HOLD_BIT] = in_hold;
				rdata_nxt[STAT_MODE_BIT] = mode_eff;
				rdata_nxt[STAT_BOOT_BIT] = boot_mode;
				rdata_nxt[STAT_SCHP_BIT] = single_chip;
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end
	end

	// register file flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pinsel_r      <= PINSEL_RST;
			mode_r        <= MODE_RST;
			s_axi_awready <= 1'h0;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			pinsel_r      <= pinsel_nxt;
			mode_r        <= mode_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rdata   <= rdata_nxt;
			s_axi_rresp   <= rresp_nxt;
		end
	end

	//==========================================
	// read lanes: take only the lanes asked for
	for (genvar i = 0; i < 2; i++) begin : g_lane
		assign lane_rd[i*8 +: 8] = cur_r.be[i] ? data_in[i*8 +: 8] : 8'h00;
	end

	//==========================================
	// bus engine: first period, then wait periods
	always_comb begin
		st_nxt    = st_r;
		cur_nxt   = cur_r;
		ready_nxt = 1'h0;
		rspv_nxt  = 1'h0;
		rsp_nxt   = rsp;
		unique case (st_r)
			ST_IDLE: begin
				if (go) begin
					ready_nxt = 1'h1;
					cur_nxt   = req;
					if (single_chip) begin
						rspv_nxt = 1'h1;
						rsp_nxt  = '{err: 1'h1, rdata: 16'h0000};
					end else begin
						st_nxt = ST_T1;
					end
				end
			end
			ST_T1: begin
				if (en) begin
					st_nxt = ST_TW;
				end
			end
			ST_TW: begin
				if (en && !wait_hold) begin
					st_nxt   = ST_IDLE;
					rspv_nxt = 1'h1;
					rsp_nxt  = '{err: 1'h0, rdata: cur_r.write ? 16'h0000 : lane_rd};
				end
			end
		endcase
	end

	// pin values for the next cycle
	always_comb begin
		logic act;
		act = 1'h0;
		act = (st_nxt != ST_IDLE);
		pins_nxt.addr          = cur_nxt.addr;
		pins_nxt.addr_oe       = !bus_float;
		pins_nxt.dout          = cur_nxt.wdata;
		pins_nxt.dout_oe       = act && cur_nxt.write && !bus_float;
		pins_nxt.area_select_n = act ? (cur_nxt.area ? 2'h1 : 2'h2) : 2'h3;
		pins_nxt.rd_n          = !(act && !cur_nxt.write);
		pins_nxt.strobe_oe     = !bus_float;
		pins_nxt.clk_wr_oe     = pinsel_r[SEL_CLKWR_BIT] && !bus_float;
		if (mode_eff) begin
			pins_nxt.high_byte_n = !(act && cur_nxt.be[1]);
			pins_nxt.low_byte_n  = !(act && cur_nxt.be[0]);
			pins_nxt.clk_wr      = !(act && cur_nxt.write);
		end else begin
			pins_nxt.high_byte_n = !(act && cur_nxt.write && cur_nxt.be[1]);
			pins_nxt.low_byte_n  = !(act && cur_nxt.write && cur_nxt.be[0]);
			pins_nxt.clk_wr      = bclk;
		end
	end

	// bus engine flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r      <= ST_IDLE;
			cur_r     <= '0;
			req_ready <= 1'h0;
			rsp_valid <= 1'h0;
			rsp       <= '0;
			bus       <= '{addr: 19'h0, addr_oe: 1'h0, dout: 16'h0, dout_oe: 1'h0,
				area_select_n: 2'h3, rd_n: 1'h1, high_byte_n: 1'h1,
				low_byte_n: 1'h1, strobe_oe: 1'h0, clk_wr: 1'h1, clk_wr_oe: 1'h0};
		end else begin
			st_r      <= st_nxt;
			cur_r     <= cur_nxt;
			req_ready <= ready_nxt;
			rsp_valid <= rspv_nxt;
			rsp       <= rsp_nxt;
			bus       <= pins_nxt;
		end
	end

	//==========================================
	// checks
	int unsigned acc_cnt;
	localparam int MINC = MIN_ACC_CLKS - 1;
	always_ff @(posedge aclk) begin
		acc_cnt <= (!aresetn || st_r == ST_IDLE) ? 0 : acc_cnt + 1;
	end
	a_min_access: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_TW && st_nxt == ST_IDLE) |-> acc_cnt >= MINC)
		else $error("access shorter than two bus periods");
	a_wait_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == ST_TW && en && wait_hold) |=> st_r == ST_TW)
		else $error("wait low ignored");
	a_read_mode0: assert property (@(posedge aclk) disable iff (!aresetn)
		(!mode_eff && st_r != ST_IDLE && !cur_r.write) |=>
		(!bus.rd_n && bus.high_byte_n && bus.low_byte_n) or $past(st_nxt == ST_IDLE))
		else $error("mode zero read strobes wrong");
	a_write_mode1: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode_eff && st_nxt != ST_IDLE && cur_nxt.write && cur_nxt.be[1]) |=>
		(!bus.clk_wr && !bus.high_byte_n && bus.rd_n))
		else $error("mode one write strobes wrong");
	a_float_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_float |=> !bus.addr_oe && !bus.dout_oe && !bus.strobe_oe)
		else $error("bus driven in hold");
	a_single_chip: assert property (@(posedge aclk) disable iff (!aresetn)
		(go && single_chip) |=> st_r == ST_IDLE ##1 !bus.strobe_oe || bus.rd_n)
		else $error("access in single chip mode");
	a_boot_mode0: assert property (@(posedge aclk) disable iff (!aresetn)
		boot_mode |-> !mode_eff)
		else $error("boot mode not forcing mode zero");
	a_axi_bresp: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awready |=> s_axi_bvalid)
		else $error("write response missing");
	c_read: cover property (@(posedge aclk) disable iff (!aresetn)
		rsp_valid && !cur_r.write);
	c_wait: cover property (@(posedge aclk) disable iff (!aresetn)
		st_r == ST_TW && en && wait_hold);
	c_mode1_write: cover property (@(posedge aclk) disable iff (!aresetn)
		mode_eff && rsp_valid && cur_r.write);
endmodule

// ---- testbench/ebm_mem_model.sv ----
`timescale 1ns/1ps
//==========================================
// external memory with its own wait driver
module ebm_mem_model
	import ebm_pkg::*;
(
	// clock and setup
	input  wire logic       aclk,
	input  wire logic       mode,
	input  wire logic [3:0] n_waits,
	// bus pins
	input  wire ebm_pins_t  bus,
	output logic [15:0]     data_in,
	output logic            wait_n
);
	logic [15:0] mem [0:15];
	logic [15:0] last_r;
	logic [4:0]  cnt_r;
	logic        act;
	logic        wr;
	// an access is under way while selected and driven
	assign act = bus.strobe_oe && (bus.area_select_n != 2'b11);
	assign wr = act && (mode ? !bus.clk_wr : 1'b1);
	// wait timed by own cycle count, held high when not stretching
	assign wait_n = !(act && (cnt_r < {n_waits, 1'b0}));
	// released lines show the inverse of the last value
	assign data_in = (act && !bus.rd_n) ? mem[bus.addr[3:0]] : ~last_r;
	// lanes stored by strobe, bits wired as on the pins
	always @(posedge aclk) begin
		last_r <= data_in;
		cnt_r <= act ? cnt_r + 5'h1 : 5'h0;
		if (wr && !bus.high_byte_n) mem[bus.addr[3:0]][15:8] <= bus.dout[15:8];
		if (wr && !bus.low_byte_n) mem[bus.addr[3:0]][7:0] <= bus.dout[7:0];
	end
endmodule

// ---- testbench/test_ebm_ext_bus.sv ----
`timescale 1ns/1ps
//==========================================
// bench for the external bus block
module test_ebm_ext_bus
	import ebm_pkg::*;
;
	logic aclk = 0, aresetn = 0, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, boot_mode, single_chip, req_valid, req_ready;
	logic rsp_valid, wait_n, hold_request_n, hold_acknowledge_n, hold_ack_oe, mode;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [3:0]  wstrb, debug_link_sel, n_waits;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  shared_pin_sel;
	logic [15:0] data_in;
	logic [18:0] sv_addr;
	logic        sv_rd, sv_hi, sv_lo, sv_wr, sv_gr, sv_hk;
	ebm_req_t    req;
	ebm_rsp_t    rsp;
	ebm_pins_t   bus;
	int          bad_count = 0, samples_checked = 0, cycles = 0, cyc;

	ebm_ext_bus dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .boot_mode(boot_mode), .single_chip(single_chip),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp(rsp), .bus(bus), .data_in(data_in), .wait_n(wait_n),
		.hold_request_n(hold_request_n), .hold_acknowledge_n(hold_acknowledge_n),
		.hold_ack_oe(hold_ack_oe), .shared_pin_sel(shared_pin_sel),
		.debug_link_sel(debug_link_sel));
	ebm_mem_model mem (.aclk(aclk), .mode(mode), .n_waits(n_waits), .bus(bus),
		.data_in(data_in), .wait_n(wait_n));

	always #2 aclk = ~aclk;
	// cycle ceiling against hangs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			results;
		end
	end
	// strobe and address watcher
	always @(posedge aclk) begin
		if (bus.strobe_oe && bus.area_select_n != 2'b11) begin
			sv_rd |= !bus.rd_n;
			sv_hi |= !bus.high_byte_n;
			sv_lo |= !bus.low_byte_n;
			sv_wr |= !bus.clk_wr;
			sv_addr = bus.addr;
		end
		if (!hold_acknowledge_n && req_ready) sv_gr = 1'b1;
		if (!hold_acknowledge_n && bus.strobe_oe && !bus.rd_n) sv_hk = 1'b1;
	end

	//==========================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// axi write: address and data offered together, each released when taken
	task automatic wreg(input logic [31:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, bresp});
	endtask
	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk(nm, exp, rdata);
		chk("read resp", {30'h0, er}, {30'h0, rresp});
	endtask
	// one cpu access; cyc counts edges from acceptance to answer
	task automatic cpu(input logic w, input logic [1:0] be, input logic [15:0] d);
		{sv_rd, sv_hi, sv_lo, sv_wr, sv_gr, sv_hk} = '0;
		req <= '{write: w, area: 1'b0, be: be, addr: 19'h40003, wdata: d};
		req_valid <= 1'b1;
		do @(posedge aclk); while (!req_ready);
		req_valid <= 1'b0;
		cyc = 0;
		while (!rsp_valid) begin
			@(posedge aclk);
			cyc++;
		end
	endtask
	// access with strobe pattern {rd, high, low, clk_wr low seen}
	task automatic acc(input logic w, input logic [1:0] be, input logic [15:0] d,
		input logic [3:0] exp);
		cpu(w, be, d);
		chk("strobes", {28'h0, exp}, {28'h0, sv_rd, sv_hi, sv_lo, sv_wr});
		chk("short access", 1, cyc >= MIN_ACC_CLKS - 1);
		chk("address", {13'h0, 19'h40003}, {13'h0, sv_addr});
	endtask

	//==========================================
	// scenarios
	task automatic t_regs;
		rchk("pin select reset", PINSEL_ADDR, 32'h0, RESP_OKAY);
		rchk("mode reset", MODE_ADDR, 32'h0, RESP_OKAY);
		wreg(PINSEL_ADDR, 32'ha5);
		chk("debug selects", 32'h5, {28'h0, debug_link_sel});
		chk("ack pin off", 32'h0, {31'h0, hold_ack_oe});
		wreg(MODE_ADDR, 32'hffffffff);
		rchk("mode bit only", MODE_ADDR, 32'h1 << MODE_BIT, RESP_OKAY);
		rchk("unmapped", MODE_ADDR + 32'h100, 32'h0, RESP_SLVERR);
		wreg(PINSEL_ADDR, 32'hf0);
		rchk("pin select", PINSEL_ADDR, 32'hf0, RESP_OKAY);
		chk("pin select out", 32'hf0, {24'h0, shared_pin_sel});
		chk("pin enables", 32'h3, {30'h0, hold_ack_oe, bus.clk_wr_oe});
		wreg(MODE_ADDR, 32'h0);
		$display("test registers done");
	endtask
	task automatic t_mode0;
		acc(1'b1, 2'b11, 16'h1234, 4'b0111);
		acc(1'b1, 2'b10, 16'ha55a, 4'b0101);
		acc(1'b0, 2'b11, 16'h0, 4'b1001);
		chk("high lane", 32'ha534, {16'h0, rsp.rdata});
		acc(1'b0, 2'b01, 16'h0, 4'b1001);
		chk("valid lane", 32'h0034, {16'h0, rsp.rdata});
		n_waits <= 4'h3;
		cpu(1'b0, 2'b11, 16'h0);
		chk("wait stretch", 1, cyc >= MIN_ACC_CLKS - 1 + 2 * 2);
		n_waits <= 4'h0;
		$display("test strobe mode done");
	endtask
	task automatic t_mode1;
		wreg(MODE_ADDR, 32'h1 << MODE_BIT);
		mode <= 1'b1;
		acc(1'b1, 2'b01, 16'h00cc, 4'b0011);
		acc(1'b1, 2'b11, 16'ha5cc, 4'b0111);
		acc(1'b0, 2'b10, 16'h0, 4'b1100);
		chk("enabled lane", 32'ha500, {16'h0, rsp.rdata});
		boot_mode <= 1'b1;
		mode <= 1'b0;
		rchk("status boot", STAT_ADDR, 32'h1 << STAT_BOOT_BIT, RESP_OKAY);
		acc(1'b0, 2'b11, 16'h0, 4'b1001);
		chk("boot data", 32'ha5cc, {16'h0, rsp.rdata});
		boot_mode <= 1'b0;
		mode <= 1'b1;
		single_chip <= 1'b1;
		cpu(1'b0, 2'b11, 16'h0);
		chk("no pins", 32'h0, {28'h0, sv_rd, sv_hi, sv_lo, sv_wr});
		chk("error", 32'h1, {31'h0, rsp.err});
		single_chip <= 1'b0;
		$display("test enable mode done");
	endtask
	task automatic t_hold;
		fork
			cpu(1'b0, 2'b11, 16'h0);
			begin
				do @(posedge aclk); while (!req_ready);
				hold_request_n <= 1'b0;
			end
		join
		while (hold_acknowledge_n) @(posedge aclk);
		chk("grant mid cycle", 32'h0, {31'h0, sv_hk});
		repeat (3) @(posedge aclk);
		chk("float", 32'h0, {29'h0, bus.addr_oe, bus.dout_oe, bus.strobe_oe});
		chk("ack pin", 32'h1, {31'h0, hold_ack_oe});
		fork
			cpu(1'b0, 2'b11, 16'h0);
			begin
				repeat (20) @(posedge aclk);
				hold_request_n <= 1'b1;
			end
		join
		chk("no access in hold", 32'h0, {31'h0, sv_gr});
		chk("ack released", 32'h1, {31'h0, hold_acknowledge_n});
		chk("resumed data", 32'ha5cc, {16'h0, rsp.rdata});
		$display("test hold done");
	endtask

	initial begin
		{awvalid, wvalid, arvalid, req_valid, boot_mode, single_chip, mode} = '0;
		{awaddr, wdata, araddr} = '0;
		req = '0;
		{bready, rready, hold_request_n} = 3'b111;
		wstrb = 4'hf;
		n_waits = 4'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_mode0;
		t_mode1;
		t_hold;
		results;
	end
endmodule
